// *** perf_mon_cfg.svh ***
// register offsets, reset values and timing constants of the per-second monitor
`ifndef PERF_MON_CFG_SVH
`define PERF_MON_CFG_SVH
`define PM_CLK_PERIOD_NS   5
`define PM_SECOND_NS       1000000000
`define PM_TICK_CYCLES     (`PM_SECOND_NS / `PM_CLK_PERIOD_NS)
`define PM_WINDOW_SECONDS  4'hA
`define PM_SES_RATIO_INV   32'h0000_03E8
`define PM_SEQ_GROUP       2'h3
`define PM_OFF_CTRL        8'h00
`define PM_OFF_STATE       8'h04
`define PM_OFF_INT_STATUS  8'h08
`define PM_OFF_INT_MASK    8'h0C
`define PM_OFF_TOTAL       8'h10
`define PM_OFF_UNAVAIL     8'h14
`define PM_OFF_AVAIL       8'h18
`define PM_OFF_ERRORED     8'h1C
`define PM_OFF_SEVERE      8'h20
`define PM_OFF_ALARM       8'h24
`define PM_OFF_ERRFREE     8'h28
`define PM_OFF_SEQ_ERR     8'h2C
`define PM_OFF_SEQ_LOSS    8'h30
`define PM_CTRL_RESET      1'h1
`define PM_INT_W           5
`define PM_INT_SECOND      0
`define PM_INT_ENTER_UA    1
`define PM_INT_LEAVE_UA    2
`define PM_INT_SEQ_ERR     3
`define PM_INT_SEQ_LOSS    4
`endif

// *** perf_mon_pkg.sv ***
// types shared by the per-second monitor
package perf_mon_pkg;
   typedef enum logic {ST_AVAIL, ST_UNAVAIL} avail_e;
   typedef struct packed {
      logic errored_second;
      logic severe_err_second;
      logic alarm_second;
      logic error_free_second;
   } sec_class_s;
   typedef logic [31:0] count_t;
endpackage : perf_mon_pkg

// *** perf_second_monitor.sv ***
// per-second performance monitor with unavailability tracking and sequence checker
//
// The placing of the registers and the APB interface to the registers were left to the implementer.
`timescale 1ns/10ps
`include "perf_mon_cfg.svh"
// Function
// - an available second with at least one pattern error counts as an errored second.
// - an available second with error ratio of 1e-3 or more, loss of frame or signal is severe.
// - an available second with link down, remote fault or loss of frame is an alarm second.
// - ten consecutive severe or alarm seconds enter unavailability from the first of them.
// - ten consecutive non-severe seconds leave unavailability, ending before that run.
// - seconds of a pending start are not unavailable until confirmed, then recounted as such.
// - seconds of a pending end stay unavailable until confirmed, then all totals are corrected.
// - available time is total time minus unavailable time.
// - total time accumulates only while power is good.
// - an available second with no error of any kind counts as error free.
// - the expected next sequence number is derived from the received one.
// - sequence numbers are evaluated in groups of four frames and mismatches flag a fault.
// - one frame arriving just after its successor is a sequence error.
// - any other mismatch is a loss of sequence synchronisation.
module perf_second_monitor
   import perf_mon_pkg::*;
#(
   parameter int unsigned TICK_CYCLES = `PM_TICK_CYCLES,
   parameter int unsigned SEQ_W       = 16
) (
   input  wire logic             pclk,
   input  wire logic             presetn,
   input  wire logic             psel,
   input  wire logic             penable,
   input  wire logic             pwrite,
   input  wire logic [7:0]       paddr,
   input  wire logic [31:0]      pwdata,
   output logic      [31:0]      prdata,
   output logic                  pready,
   output logic                  pslverr,
   output logic                  irq,
   input  wire logic             power_good,
   input  wire logic             bit_valid,
   input  wire logic             pattern_err,
   input  wire logic             loss_of_frame,
   input  wire logic             loss_of_signal,
   input  wire logic             link_down,
   input  wire logic             remote_fault,
   input  wire logic             frame_valid,
   input  wire logic [SEQ_W-1:0] frame_seq
);
   ////////////////////////////////////////////////////////////////////////////
   function automatic logic [3:0] class_vec(input sec_class_s c);
      return {c.errored_second, c.severe_err_second, c.alarm_second, c.error_free_second};
   endfunction : class_vec

   logic                      meas_clr, acc, rvalid, ctrl_reg, tick_reg, sec_restart;
   logic                      any_err_reg, lof_reg, los_reg, link_reg, rf_reg;
   logic                      bad_entry, enter_ua, leave_ua, locked_reg, swap_reg;
   logic                      grp_fault_reg, seq_err_ev, seq_loss_ev;
   logic [`PM_INT_W-1:0]      int_status_reg, int_mask_reg, int_event;
   logic [31:0]               tick_cnt_reg, err_cnt_reg, bit_cnt_reg, rdata;
   sec_class_s                sec_now;
   logic [3:0]                sec_vec, run_reg;
   logic [3:0]                pend_reg [4];
   count_t                    cnt_reg  [4];
   count_t                    total_reg, unavail_reg, avail_reg, seq_err_reg, seq_loss_reg;
   avail_e                    state_reg;
   logic [SEQ_W-1:0]          exp_reg;
   logic [1:0]                grp_reg;

   ////////////////////////////////////////////////////////////////////////////
   // apb: one wait state, write and read data take effect at the pready edge
   assign acc      = psel & penable & pready;
   assign meas_clr = acc & pwrite & (paddr == `PM_OFF_CTRL) & pwdata[1];

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready  <= 1'b0;
         prdata  <= 32'h0000_0000;
         pslverr <= 1'b0;
      end else begin
         pready  <= psel & penable & ~pready;
         prdata  <= (psel & penable & ~pready & ~pwrite) ? rdata : 32'h0000_0000;
         pslverr <= psel & penable & ~pready & ~rvalid;
      end
   end

   always_comb begin
      rvalid = 1'b1;
      case (paddr)
         `PM_OFF_CTRL:       rdata = {31'h0, ctrl_reg};
         `PM_OFF_STATE:      rdata = {25'h0, grp_fault_reg, locked_reg, run_reg,
                                      (state_reg == ST_UNAVAIL)};
         `PM_OFF_INT_STATUS: rdata = {27'h0, int_status_reg};
         `PM_OFF_INT_MASK:   rdata = {27'h0, int_mask_reg};
         `PM_OFF_TOTAL:      rdata = total_reg;
         `PM_OFF_UNAVAIL:    rdata = unavail_reg;
         `PM_OFF_AVAIL:      rdata = avail_reg;
         `PM_OFF_ERRORED:    rdata = cnt_reg[3];
         `PM_OFF_SEVERE:     rdata = cnt_reg[2];
         `PM_OFF_ALARM:      rdata = cnt_reg[1];
         `PM_OFF_ERRFREE:    rdata = cnt_reg[0];
         `PM_OFF_SEQ_ERR:    rdata = seq_err_reg;
         `PM_OFF_SEQ_LOSS:   rdata = seq_loss_reg;
         default: begin
            rdata  = 32'h0000_0000;
            rvalid = 1'b0;
         end
      endcase
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctrl_reg     <= `PM_CTRL_RESET;
         int_mask_reg <= '0;
      end else if (acc & pwrite & (paddr == `PM_OFF_CTRL)) begin
         ctrl_reg <= pwdata[0];
      end else if (acc & pwrite & (paddr == `PM_OFF_INT_MASK)) begin
         int_mask_reg <= pwdata[`PM_INT_W-1:0];
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // sticky events; a set in the clearing cycle wins
   assign int_event = {seq_loss_ev, seq_err_ev, leave_ua, enter_ua, tick_reg};

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         int_status_reg <= '0;
         irq            <= 1'b0;
      end else begin
         if (acc & pwrite & (paddr == `PM_OFF_INT_STATUS))
            int_status_reg <= (int_status_reg & ~pwdata[`PM_INT_W-1:0]) | int_event;
         else
            int_status_reg <= int_status_reg | int_event;
         irq <= |(int_status_reg & int_mask_reg);
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // second tick and per-second accumulation
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         tick_cnt_reg <= 32'h0000_0000;
         tick_reg     <= 1'b0;
      end else if (meas_clr || tick_cnt_reg == TICK_CYCLES - 1) begin
         tick_cnt_reg <= 32'h0000_0000;
         tick_reg     <= ~meas_clr & ctrl_reg & power_good;
      end else begin
         tick_cnt_reg <= tick_cnt_reg + 32'h0000_0001;
         tick_reg     <= 1'b0;
      end
   end

   // indications of the finishing second are latched as the tick fires
   assign sec_restart = tick_reg | meas_clr;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         err_cnt_reg <= 32'h0000_0000;
         bit_cnt_reg <= 32'h0000_0000;
         any_err_reg <= 1'b0;
         lof_reg     <= 1'b0;
         los_reg     <= 1'b0;
         link_reg    <= 1'b0;
         rf_reg      <= 1'b0;
      end else begin
         err_cnt_reg <= (sec_restart ? 32'h0000_0000 : err_cnt_reg) + {31'h0, pattern_err};
         bit_cnt_reg <= (sec_restart ? 32'h0000_0000 : bit_cnt_reg) + {31'h0, bit_valid};
         any_err_reg <= (any_err_reg & ~sec_restart) | pattern_err;
         lof_reg     <= (lof_reg & ~sec_restart) | loss_of_frame;
         los_reg     <= (los_reg & ~sec_restart) | loss_of_signal;
         link_reg    <= (link_reg & ~sec_restart) | link_down;
         rf_reg      <= (rf_reg & ~sec_restart) | remote_fault;
      end
   end

   always_comb begin
      sec_now.errored_second    = any_err_reg;
      sec_now.severe_err_second = lof_reg | los_reg | (bit_cnt_reg != 32'h0 &&
         ({32'h0, err_cnt_reg} * {32'h0, `PM_SES_RATIO_INV}) >= {32'h0, bit_cnt_reg});
      sec_now.alarm_second      = link_reg | rf_reg | lof_reg;
      sec_now.error_free_second = ~(any_err_reg | lof_reg | los_reg | link_reg | rf_reg);
   end
   assign sec_vec   = class_vec(sec_now);
   assign bad_entry = sec_now.severe_err_second | sec_now.alarm_second;
   assign enter_ua  = tick_reg & (state_reg == ST_AVAIL) & bad_entry &
                      (run_reg == `PM_WINDOW_SECONDS - 4'h1);
   assign leave_ua  = tick_reg & (state_reg == ST_UNAVAIL) & ~sec_now.severe_err_second &
                      (run_reg == `PM_WINDOW_SECONDS - 4'h1);

   ////////////////////////////////////////////////////////////////////////////
   // availability state and window run
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state_reg <= ST_AVAIL;
         run_reg   <= 4'h0;
      end else if (meas_clr) begin
         state_reg <= ST_AVAIL;
         run_reg   <= 4'h0;
      end else if (tick_reg) begin
         case (state_reg)
            ST_AVAIL: begin
               run_reg <= (bad_entry & ~enter_ua) ? run_reg + 4'h1 : 4'h0;
               if (enter_ua) state_reg <= ST_UNAVAIL;
            end
            ST_UNAVAIL: begin
               run_reg <= (sec_now.severe_err_second | leave_ua) ? 4'h0 : run_reg + 4'h1;
               if (leave_ua) state_reg <= ST_AVAIL;
            end
            default: begin
               state_reg <= ST_AVAIL;
               run_reg   <= 4'h0;
            end
         endcase
      end
   end

   // provisional counts of the open window, used to correct totals at the verdict
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         for (int i = 0; i < 4; i++) begin
            pend_reg[i] <= 4'h0;
            cnt_reg[i]  <= 32'h0000_0000;
         end
      end else if (meas_clr) begin
         for (int i = 0; i < 4; i++) begin
            pend_reg[i] <= 4'h0;
            cnt_reg[i]  <= 32'h0000_0000;
         end
      end else if (tick_reg) begin
         for (int i = 0; i < 4; i++) begin
            if (state_reg == ST_AVAIL) begin
               if (enter_ua) begin
                  // window seconds leave the available counts
                  cnt_reg[i]  <= cnt_reg[i] - {28'h0, pend_reg[i]};
                  pend_reg[i] <= 4'h0;
               end else begin
                  cnt_reg[i]  <= cnt_reg[i] + {31'h0, sec_vec[i]};
                  pend_reg[i] <= bad_entry ? pend_reg[i] + {3'h0, sec_vec[i]} : 4'h0;
               end
            end else if (leave_ua) begin
               cnt_reg[i]  <= cnt_reg[i] + {28'h0, pend_reg[i]} + {31'h0, sec_vec[i]};
               pend_reg[i] <= 4'h0;
            end else begin
               pend_reg[i] <= sec_now.severe_err_second ? 4'h0
                                                        : pend_reg[i] + {3'h0, sec_vec[i]};
            end
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         total_reg   <= 32'h0000_0000;
         unavail_reg <= 32'h0000_0000;
         avail_reg   <= 32'h0000_0000;
      end else if (meas_clr) begin
         total_reg   <= 32'h0000_0000;
         unavail_reg <= 32'h0000_0000;
         avail_reg   <= 32'h0000_0000;
      end else begin
         avail_reg <= total_reg - unavail_reg;
         if (tick_reg) begin
            total_reg <= total_reg + 32'h0000_0001;
            if (enter_ua)
               unavail_reg <= unavail_reg + {28'h0, `PM_WINDOW_SECONDS};
            else if (leave_ua)
               unavail_reg <= unavail_reg + 32'h0000_0001
                              - {28'h0, `PM_WINDOW_SECONDS};
            else if (state_reg == ST_UNAVAIL)
               unavail_reg <= unavail_reg + 32'h0000_0001;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // sequence checker; a swapped pair waits one frame for its late partner
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         exp_reg       <= '0;
         locked_reg    <= 1'b0;
         swap_reg      <= 1'b0;
         grp_reg       <= 2'h0;
         grp_fault_reg <= 1'b0;
         seq_err_ev    <= 1'b0;
         seq_loss_ev   <= 1'b0;
         seq_err_reg   <= 32'h0000_0000;
         seq_loss_reg  <= 32'h0000_0000;
      end else begin
         seq_err_ev   <= 1'b0;
         seq_loss_ev  <= 1'b0;
         seq_err_reg  <= seq_err_reg + {31'h0, seq_err_ev};
         seq_loss_reg <= seq_loss_reg + {31'h0, seq_loss_ev};
         if (meas_clr) begin
            locked_reg    <= 1'b0;
            swap_reg      <= 1'b0;
            grp_reg       <= 2'h0;
            grp_fault_reg <= 1'b0;
            seq_err_reg   <= 32'h0000_0000;
            seq_loss_reg  <= 32'h0000_0000;
         end else if (frame_valid) begin
            grp_reg <= grp_reg + 2'h1;
            if (grp_reg == `PM_SEQ_GROUP)
               grp_fault_reg <= 1'b0;
            if (!locked_reg) begin
               locked_reg <= 1'b1;
               exp_reg    <= frame_seq + 1'b1;
            end else if (swap_reg) begin
               swap_reg <= 1'b0;
               if (frame_seq == exp_reg) begin
                  seq_err_ev <= 1'b1;
                  exp_reg    <= exp_reg + 2'd2;
               end else begin
                  seq_loss_ev   <= 1'b1;
                  grp_fault_reg <= 1'b1;
                  exp_reg       <= frame_seq + 1'b1;
               end
            end else if (frame_seq != exp_reg) begin
               grp_fault_reg <= 1'b1;
               if (frame_seq == exp_reg + 1'b1) begin
                  swap_reg <= 1'b1;
               end else begin
                  seq_loss_ev <= 1'b1;
                  exp_reg     <= frame_seq + 1'b1;
               end
            end else begin
               exp_reg <= frame_seq + 1'b1;
            end
         end
      end
   end

endmodule : perf_second_monitor

// *** perf_mon_sva.sv ***
// bus and interrupt checker bound to the per-second monitor
`timescale 1ns/10ps
module perf_mon_chk (
   input wire logic        pclk,
   input wire logic        presetn,
   input wire logic        psel,
   input wire logic        penable,
   input wire logic        pwrite,
   input wire logic [7:0]  paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic        pready,
   input wire logic        pslverr,
   input wire logic        irq
);
   default clocking dc @(posedge pclk);
   endclocking
   default disable iff (!presetn);

   a_ready_one_wait: assert property (psel && penable && !$past(penable) |-> !pready ##1 pready)
      else $error("pready not after exactly one wait state");
   a_ready_pulse: assert property (pready |=> !pready)
      else $error("pready held longer than one cycle");
   a_ready_in_access: assert property (pready |-> psel && penable && $past(psel && penable))
      else $error("pready outside an access phase");
   a_rdata_idle: assert property (!pready |-> prdata == 32'h0000_0000)
      else $error("read data not zero outside an answer");
   a_err_unmapped: assert property (pready && paddr > 8'h30 |-> pslverr && (pwrite || prdata == 0))
      else $error("unmapped access not refused");
   a_err_mapped: assert property (pready && paddr <= 8'h30 && paddr[1:0] == 2'h0 |-> !pslverr)
      else $error("mapped access refused");
   a_ctrl_pulse_bit: assert property (pready && !pwrite && paddr == 8'h00 |-> !prdata[1])
      else $error("measurement reset bit reads back set");
   a_irq_mask_off: assert property (
      psel && penable && pready && pwrite && paddr == 8'h0C && pwdata[4:0] == 5'h00 |-> ##2 !irq)
      else $error("interrupt stays up with all sources masked");
endmodule : perf_mon_chk
////////////////////////////////////////////////////////////////////////////////
bind perf_second_monitor perf_mon_chk chk (
   .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
   .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
   .irq(irq));

// *** rx_path_model.sv ***
// receive path model: per-second error, alarm and power indications
`timescale 1ns/10ps
module rx_path_model #(
   parameter int unsigned TICK = 1200
) (
   input  wire logic       pclk,
   input  wire logic       sync,
   input  wire logic [2:0] kind,
   output logic            fstart,
   output logic            power_good,
   output logic            bit_valid,
   output logic            pattern_err,
   output logic            loss_of_frame,
   output logic            loss_of_signal,
   output logic            link_down,
   output logic            remote_fault
);
   int   cnt = 0;
   logic off_prev = 1'b0;
   initial {fstart, bit_valid, pattern_err, loss_of_frame, loss_of_signal} = 5'h00;
   initial {link_down, remote_fault, power_good} = 3'h1;
   // events sit mid-second so a few cycles of tick skew never move them
   always @(posedge pclk) begin
      cnt <= (sync || cnt == TICK - 1) ? 0 : cnt + 1;
      fstart <= !sync && cnt == TICK - 1;
      if (cnt == TICK - 1) off_prev <= kind == 3'h7;
      bit_valid <= 1'b1;
      pattern_err <= (kind == 3'h1 && cnt == 400) || (kind == 3'h2 && (cnt == 400 || cnt == 450));
      loss_of_frame <= kind == 3'h3 && cnt >= 400 && cnt < 500;
      loss_of_signal <= kind == 3'h4 && cnt >= 400 && cnt < 500;
      link_down <= kind == 3'h5 && cnt >= 400 && cnt < 500;
      remote_fault <= kind == 3'h6 && cnt >= 400 && cnt < 500;
      // power drop straddles exactly one tick
      power_good <= !((kind == 3'h7 && cnt >= TICK / 2) || (off_prev && cnt < TICK / 2));
   end
endmodule : rx_path_model

// *** testbench.sv ***
// self-checking bench for the per-second monitor
`timescale 1ns/10ps
`include "perf_mon_cfg.svh"
module testbench;
   localparam int unsigned TICK = 1200;
   localparam logic [31:0] ALL  = 32'hFFFF_FFFF;
   logic        pclk = 1'b0;
   logic        presetn = 1'b0;
   logic        psel = 1'b0;
   logic        penable = 1'b0;
   logic        pwrite = 1'b0;
   logic [7:0]  paddr = 8'h00;
   logic [31:0] pwdata = 32'h0000_0000;
   logic        frame_valid = 1'b0;
   logic [15:0] frame_seq = 16'h0000;
   logic        msync = 1'b0;
   logic [2:0]  kind = 3'h0;
   logic [31:0] prdata, rdv;
   logic        pready, pslverr, irq, errv, fstart;
   logic        power_good, bit_valid, pattern_err, loss_of_frame;
   logic        loss_of_signal, link_down, remote_fault;
   logic [15:0] expn, base;
   int          bad_count = 0, tests_run = 0, seed = 39;
   int          total, unav, ne, ns, na, nf, serr, sloss;
   bit          unav_st, locked, pend;
   int          q[$];
   int          offs[10] = '{1, 2, 4, 3, 5, 6, 7, 9, 10, 20};
   int          plan_k[34] = '{0, 1, 2, 3, 4, 5, 6, 7, 0, 4, 4, 4, 4, 4, 4, 4, 4, 4, 4,
                               5, 5, 5, 4, 0, 0, 0, 0, 0, 0, 0, 0, 0, 0, 0};
   always #2.5 pclk = ~pclk;
   perf_second_monitor #(.TICK_CYCLES(TICK), .SEQ_W(16)) dut (
      .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .irq(irq), .power_good(power_good), .bit_valid(bit_valid), .pattern_err(pattern_err),
      .loss_of_frame(loss_of_frame), .loss_of_signal(loss_of_signal), .link_down(link_down),
      .remote_fault(remote_fault), .frame_valid(frame_valid), .frame_seq(frame_seq));
   rx_path_model #(.TICK(TICK)) rx (
      .pclk(pclk), .sync(msync), .kind(kind), .fstart(fstart), .power_good(power_good),
      .bit_valid(bit_valid), .pattern_err(pattern_err), .loss_of_frame(loss_of_frame),
      .loss_of_signal(loss_of_signal), .link_down(link_down), .remote_fault(remote_fault));
////////////////////////////////////////////////////////////////////////////////
   task automatic conclude();
      $display("compares %0d, mismatches %0d", tests_run, bad_count);
      if (bad_count == 0 && tests_run > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask : conclude
   task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
      tests_run++;
      if (got !== exp) begin
         bad_count++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : cmp
   // idle cycle first, so a strobe is never driven twice in one step
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      // only the watchdog ends a wait for the answer
      do @(posedge pclk);
      while (pready !== 1'b1);
      rdv = prdata;
      errv = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb
   task automatic chk(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
      apb(1'b0, a, 32'h0000_0000);
      cmp(rdv & m, e);
   endtask : chk
   task automatic tally(input int k, input int d);
      ne += d * (k == 1 || k == 2);
      ns += d * (k == 2 || k == 3 || k == 4);
      na += d * (k == 3 || k == 5 || k == 6);
      nf += d * (k == 0);
   endtask : tally
   task automatic sec(input int k);
      int n;
      kind <= k[2:0];
      n = 0;
      do begin
         @(posedge pclk);
         n++;
      end while (fstart !== 1'b1 && n < 2 * TICK);
      if (n >= 2 * TICK) bad_count++;
      if (k == 7) return;
      total++;
      if (!unav_st) begin
         tally(k, 1);
         if (k != 0 && k != 1) q.push_back(k);
         else q.delete();
      end else begin
         unav++;
         if (k < 2 || k > 4) q.push_back(k);
         else q.delete();
      end
      if (q.size() == 10) begin
         unav += unav_st ? -10 : 10;
         foreach (q[j]) tally(q[j], unav_st ? 1 : -1);
         unav_st = !unav_st;
         q.delete();
      end
   endtask : sec
   task automatic counters();
      repeat (5) @(posedge pclk);
      chk(`PM_OFF_TOTAL, ALL, total);
      chk(`PM_OFF_UNAVAIL, ALL, unav);
      chk(`PM_OFF_AVAIL, ALL, total - unav);
      chk(`PM_OFF_ERRORED, ALL, ne);
      chk(`PM_OFF_SEVERE, ALL, ns);
      chk(`PM_OFF_ALARM, ALL, na);
      chk(`PM_OFF_ERRFREE, ALL, nf);
      chk(`PM_OFF_STATE, 32'h1, unav_st);
   endtask : counters
   task automatic frame(input logic [15:0] s);
      @(posedge pclk);
      frame_valid <= 1'b1;
      frame_seq <= s;
      @(posedge pclk);
      frame_valid <= 1'b0;
      frame_seq <= ~s;
      repeat (2 + ($unsigned($random(seed)) % 4)) @(posedge pclk);
      if (!locked) begin
         locked = 1;
         expn = s + 16'h0001;
      end else if (pend) begin
         pend = 0;
         if (s == expn) serr++;
         else sloss++;
         // late frame closes the swap: both numbers are now consumed
         expn = (s == expn) ? expn + 16'h0002 : s + 16'h0001;
      end else if (s == expn + 16'h0001) pend = 1;
      else begin
         if (s != expn) sloss++;
         expn = s + 16'h0001;
      end
   endtask : frame
////////////////////////////////////////////////////////////////////////////////
   initial begin
      repeat (60000) @(posedge pclk);
      bad_count++;
      conclude();
   end
   initial begin
      {total, unav, ne, ns, na, nf, serr, sloss} = '0;
      {unav_st, locked, pend} = 3'h0;
      repeat (8) @(posedge pclk);
      presetn <= 1'b1;
      chk(`PM_OFF_CTRL, 32'h3, 32'h1);
      chk(`PM_OFF_INT_MASK, ALL, 32'h0);
      chk(`PM_OFF_STATE, 32'h7F, 32'h0);
      chk(`PM_OFF_TOTAL, ALL, 32'h0);
      chk(8'h3C, ALL, 32'h0);
      cmp(errv, 1'b1);
      $display("test reset done");
      apb(1'b1, `PM_OFF_INT_MASK, 32'h0000_0008);
      base = $random(seed) & 32'h7FFF;
      foreach (offs[i]) frame(base + offs[i][15:0]);
      chk(`PM_OFF_SEQ_ERR, ALL, serr);
      chk(`PM_OFF_SEQ_LOSS, ALL, sloss);
      chk(`PM_OFF_STATE, 32'h60, 32'h60);
      chk(`PM_OFF_INT_STATUS, 32'h18, 32'h18);
      cmp(irq, 1'b1);
      apb(1'b1, `PM_OFF_INT_STATUS, 32'h0000_0008);
      repeat (3) @(posedge pclk);
      cmp(irq, 1'b0);
      apb(1'b1, `PM_OFF_INT_MASK, 32'h0000_0000);
      chk(`PM_OFF_INT_STATUS, 32'h18, 32'h10);
      $display("test sequence done");
      apb(1'b1, `PM_OFF_CTRL, 32'h0000_0003);
      msync <= 1'b1;
      @(posedge pclk);
      msync <= 1'b0;
      chk(`PM_OFF_SEQ_ERR, ALL, 32'h0);
      foreach (plan_k[i]) begin
         sec(plan_k[i]);
         counters();
         if (i == 8 || i == 18) $display("test seconds %0d done", i);
      end
      chk(`PM_OFF_INT_STATUS, 32'h6, 32'h6);
      $display("test unavailability done");
      conclude();
   end
endmodule : testbench
